//--- src/rtcs_top.sv
// Serial slave port, interrupt output and mode logic of a real-time clock.
// Assumes an SPI master on the pins, timekeeping logic on alarm/periodic
// inputs, and an AXI4-Lite master on the same clock.
// Function
// - Bytes from host arrive MSB first and are assembled in that order.
// - Transfer is one address/control byte then data bytes, MSB first.
// - On reads the device shifts requested bytes out MSB first.
// - Chip enable low holds the serial logic reset, dropping partial transfers.
// - Chip enable low disables the serial output driver.
// - Interrupt output is active low open drain, low only for enabled events.
// - Power-sense enable set and power failure drive the interrupt low.
// - Reaching the alarm time asserts the interrupt.
// - Alarm flag and interrupt lag the match by a crystal-dependent time.
// - Periodic interval asserts the interrupt until the status register is read.
// - Status read also releases power-sense and alarm interrupts.
// - Any interrupt assertion cancels a selected power-down state.
// - Status bit reads one while any interrupt is valid.
// - Power-on reset resets the device; supply level at its end picks mode.
// - Serial clock latches input bits and shifts output bits.
// - Address bit 5 low selects RAM, bits 4 to 0 the location.
`include "rtcs_cfg.svh"
module rtcs_top
  import rtcs_pkg::*;
#(
  parameter int RAM_AW = 5
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sck_pin,
  input  wire logic        ce_pin,
  input  wire logic        mosi_pin,
  output logic             miso_o,
  output logic             miso_oe,
  output logic             int_o,
  output logic             int_oe,
  input  wire logic        por_n_pin,
  input  wire logic        vdd_pin,
  input  wire logic        alarm_match,
  input  wire logic        periodic_tick,
  output logic             pwr_down,
  output logic             supply_mode,
  output logic             irq
);
  rtcs_state_type st_r;
  rtcs_state_type st_nxt;
  logic           ce_s;
  logic           sck_s;
  logic           mosi_s;
  logic           vdd_s;
  logic           por_s;
  logic           sck_rise;
  logic           sck_fall;
  logic [7:0]     rx_byte;
  logic           int_any;
  logic           int_rise;
  logic           pf_set;
  logic           alm_set;
  logic           per_set;
  logic           stat_rd;
  logic           byte_done;
  logic           ram_we;
  logic [7:0]     ram_rdata;
  logic [2:0]     evt_clr;

  function automatic logic [10:0] lag_cycles(input logic [1:0] xtal);
    unique case (xtal)
      `RTCS_XTAL_32K: lag_cycles = 11'(`RTCS_LAG_32K_CYC - 1);
      `RTCS_XTAL_2M:  lag_cycles = 11'(`RTCS_LAG_2M_CYC - 1);
      default:        lag_cycles = 11'(`RTCS_LAG_4M_CYC - 1);
    endcase
  endfunction

  function automatic logic [7:0] status_byte(input rtcs_state_type s);
    status_byte = 8'h00;
    status_byte[`RTCS_ST_INT] = s.pf_flag | s.alm_flag | s.per_flag;
    status_byte[`RTCS_ST_PF]  = s.pf_flag;
    status_byte[`RTCS_ST_ALM] = s.alm_flag;
    status_byte[`RTCS_ST_PER] = s.per_flag;
    status_byte[`RTCS_ST_SUP] = s.supply;
  endfunction

  assign ce_s     = st_r.sync2[`RTCS_PIN_CE];
  assign sck_s    = st_r.sync2[`RTCS_PIN_SCK];
  assign mosi_s   = st_r.sync2[`RTCS_PIN_MOSI];
  assign vdd_s    = st_r.sync2[`RTCS_PIN_VDD];
  assign por_s    = st_r.sync2[`RTCS_PIN_POR];
  assign sck_rise = sck_s & ~st_r.sck_d;
  assign sck_fall = ~sck_s & st_r.sck_d;
  assign rx_byte  = {st_r.sh_in[6:0], mosi_s};
  assign int_any  = st_r.pf_flag | st_r.alm_flag | st_r.per_flag;
  assign int_rise = int_any & ~st_r.int_d;
  // Failure seen as the supply pin falling
  assign pf_set   = st_r.vdd_d & ~vdd_s & st_r.icr[`RTCS_ICR_PSE];
  assign alm_set  = st_r.alm_cnt == 11'h001;
  assign per_set  = periodic_tick & st_r.icr[`RTCS_ICR_PEN];

  rtcs_ram #(
    .AW (RAM_AW),
    .DW (8)
  ) u_ram (
    .clock (clock),
    .we    (ram_we),
    .waddr (st_r.adr[RAM_AW-1:0]),
    .wdata (rx_byte),
    .raddr (st_nxt.adr[RAM_AW-1:0]),
    .rdata (ram_rdata)
  );

  always_comb begin
    st_nxt    = st_r;
    stat_rd   = 1'b0;
    byte_done = 1'b0;
    ram_we    = 1'b0;
    evt_clr   = 3'h0;
    st_nxt.sync1 = {por_n_pin, vdd_pin, mosi_pin, sck_pin, ce_pin};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sck_d = sck_s;
    st_nxt.vdd_d = vdd_s;
    st_nxt.por_d = por_s;

    // Serial slave
    if (!ce_s) begin
      st_nxt.spi     = RTCS_IDLE;
      st_nxt.bit_cnt = 3'h0;
      st_nxt.ld_pend = 1'b0;
      st_nxt.miso    = 1'b0;
    end else begin
      if (st_r.spi == RTCS_IDLE) begin
        st_nxt.spi = RTCS_ADDR;
      end
      if (sck_rise) begin
        st_nxt.sh_in   = rx_byte;
        st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
        if (st_r.bit_cnt == 3'h7) begin
          byte_done = 1'b1;
          unique case (st_r.spi)
            RTCS_ADDR: begin
              st_nxt.adr     = rx_byte;
              st_nxt.wr      = rx_byte[`RTCS_ADR_WR];
              st_nxt.ld_pend = ~rx_byte[`RTCS_ADR_WR];
              st_nxt.spi     = RTCS_DATA;
            end
            RTCS_DATA: begin
              if (st_r.wr) begin
                if (!st_r.adr[`RTCS_ADR_REG]) begin
                  ram_we = 1'b1;
                end else if (st_r.adr[5:0] == `RTCS_REG_ICR) begin
                  st_nxt.icr = rx_byte;
                end
              end
              // Auto increment wraps inside the 32-byte window
              st_nxt.adr[4:0] = st_r.adr[4:0] + 5'h01;
              st_nxt.ld_pend  = ~st_r.wr;
            end
            RTCS_IDLE: begin
              st_nxt.spi = RTCS_ADDR;
            end
            default: begin
              st_nxt.spi = RTCS_IDLE;
            end
          endcase
        end
      end
      if (sck_fall) begin
        st_nxt.miso   = st_r.sh_out[7];
        st_nxt.sh_out = {st_r.sh_out[6:0], 1'b0};
      end
      // Load lands between the last rise and the next fall of the link clock
      if (st_r.ld_pend) begin
        st_nxt.ld_pend = 1'b0;
        if (!st_r.adr[`RTCS_ADR_REG]) begin
          st_nxt.sh_out = ram_rdata;
        end else if (st_r.adr[5:0] == `RTCS_REG_STAT) begin
          st_nxt.sh_out = status_byte(st_r);
          stat_rd       = 1'b1;
        end else if (st_r.adr[5:0] == `RTCS_REG_ICR) begin
          st_nxt.sh_out = st_r.icr;
        end else begin
          st_nxt.sh_out = 8'h00;
        end
      end
    end

    // Interrupt sources; a new event beats the status-read release
    if (alarm_match && st_r.icr[`RTCS_ICR_AEN] && st_r.alm_cnt == 11'h000) begin
      st_nxt.alm_cnt = lag_cycles(st_r.xtal);
    end else if (st_r.alm_cnt != 11'h000) begin
      st_nxt.alm_cnt = st_r.alm_cnt - 11'h001;
    end
    st_nxt.pf_flag  = (st_r.pf_flag & ~stat_rd) | pf_set;
    st_nxt.alm_flag = (st_r.alm_flag & ~stat_rd) | alm_set;
    st_nxt.per_flag = (st_r.per_flag & ~stat_rd) | per_set;
    st_nxt.int_d    = int_any;

    // Mode: battery backup leaves on a supply rise
    if (vdd_s && !st_r.vdd_d) begin
      st_nxt.supply = 1'b1;
    end
    if (por_s && !st_r.por_d) begin
      st_nxt.supply = vdd_s;
    end

    // AXI4-Lite write
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.ax.aw_ok  = 1'b1;
      st_nxt.ax.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.ax.w_ok  = 1'b1;
      st_nxt.ax.wdata = s_axi_wdata;
      st_nxt.ax.wstrb = s_axi_wstrb;
    end
    if (st_r.ax.aw_ok && st_r.ax.w_ok && !st_r.ax.bvalid) begin
      st_nxt.ax.aw_ok  = 1'b0;
      st_nxt.ax.w_ok   = 1'b0;
      st_nxt.ax.bvalid = 1'b1;
      st_nxt.ax.bresp  = `RTCS_RESP_OKAY;
      unique case (st_r.ax.awaddr)
        `RTCS_AX_EVT: begin
          if (st_r.ax.wstrb[0]) begin
            evt_clr = st_r.ax.wdata[2:0];
          end
        end
        `RTCS_AX_MASK: begin
          if (st_r.ax.wstrb[0]) begin
            st_nxt.mask = st_r.ax.wdata[2:0];
          end
        end
        `RTCS_AX_CTRL: begin
          if (st_r.ax.wstrb[0]) begin
            st_nxt.pdn  = st_r.pdn | st_r.ax.wdata[`RTCS_CTRL_PDN];
            st_nxt.xtal = st_r.ax.wdata[`RTCS_CTRL_XTAL +: 2];
          end
        end
        `RTCS_AX_STATE: begin
          st_nxt.ax.bresp = `RTCS_RESP_OKAY;
        end
        default: begin
          st_nxt.ax.bresp = `RTCS_RESP_SLVERR;
        end
      endcase
    end
    if (st_r.ax.bvalid && s_axi_bready) begin
      st_nxt.ax.bvalid = 1'b0;
    end

    // AXI4-Lite read
    if (st_r.ax.rvalid && s_axi_rready) begin
      st_nxt.ax.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.ax.rvalid = 1'b1;
      st_nxt.ax.rresp  = `RTCS_RESP_OKAY;
      unique case (s_axi_araddr)
        `RTCS_AX_EVT:   st_nxt.ax.rdata = {29'h0, st_r.evt};
        `RTCS_AX_MASK:  st_nxt.ax.rdata = {29'h0, st_r.mask};
        `RTCS_AX_CTRL:  st_nxt.ax.rdata = {29'h0, st_r.xtal, st_r.pdn};
        `RTCS_AX_STATE: st_nxt.ax.rdata = {14'h0, st_r.pdn, st_r.supply, status_byte(st_r), st_r.icr};
        default: begin
          st_nxt.ax.rdata = 32'h0;
          st_nxt.ax.rresp = `RTCS_RESP_SLVERR;
        end
      endcase
    end

    // Interrupt wakes the part; beats a power-down written in the same cycle
    if (int_rise) begin
      st_nxt.pdn = 1'b0;
    end
    st_nxt.evt = (st_r.evt & ~evt_clr)
               | {int_rise & st_r.pdn, int_rise, byte_done};

    // Pin-held power-on reset clears everything but the bus, synchronisers and vdd_d
    if (!por_s) begin
      st_nxt       = '0;
      st_nxt.sync1 = {por_n_pin, vdd_pin, mosi_pin, sck_pin, ce_pin};
      st_nxt.sync2 = st_r.sync1;
      st_nxt.vdd_d = vdd_s;
      st_nxt.ax    = st_r.ax;
      st_nxt.ax.aw_ok = st_r.ax.aw_ok | (s_axi_awvalid & s_axi_awready);
      st_nxt.ax.w_ok  = st_r.ax.w_ok | (s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        st_nxt.ax.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        st_nxt.ax.wdata = s_axi_wdata;
        st_nxt.ax.wstrb = s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = ~st_r.ax.aw_ok & ~st_r.ax.bvalid;
  assign s_axi_wready  = ~st_r.ax.w_ok & ~st_r.ax.bvalid;
  assign s_axi_bvalid  = st_r.ax.bvalid;
  assign s_axi_bresp   = st_r.ax.bresp;
  assign s_axi_arready = ~st_r.ax.rvalid;
  assign s_axi_rvalid  = st_r.ax.rvalid;
  assign s_axi_rdata   = st_r.ax.rdata;
  assign s_axi_rresp   = st_r.ax.rresp;
  assign miso_o        = st_r.miso;
  assign miso_oe       = ce_s & (st_r.spi == RTCS_DATA) & ~st_r.wr;
  assign int_o         = 1'b0;
  assign int_oe        = int_any;
  assign pwr_down      = st_r.pdn;
  assign supply_mode   = st_r.supply;
  assign irq           = |(st_r.evt & st_r.mask);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst || !por_s);

  a_spi_ce_reset: assert property (
    !ce_s |=> (st_r.spi == RTCS_IDLE) && (st_r.bit_cnt == 3'h0) && !st_r.ld_pend)
    else $error("serial logic not held reset with chip enable low");

  a_miso_ce_off: assert property (
    !ce_pin [*3] |-> !miso_oe)
    else $error("serial output driven with chip enable low");

  a_int_open_drain: assert property (
    int_oe |-> (int_o == 1'b0) && (st_r.pf_flag || st_r.alm_flag || st_r.per_flag))
    else $error("interrupt pin driven without a pending event");

  a_pf_drives_int: assert property (
    pf_set |=> int_oe && st_r.pf_flag)
    else $error("enabled power failure did not pull interrupt low");

  a_alarm_lag_hold: assert property (
    (alarm_match && st_r.icr[`RTCS_ICR_AEN] && st_r.alm_cnt == 11'h000 && !st_r.alm_flag)
    |=> !st_r.alm_flag [*8])
    else $error("alarm flag set without the required lag");

  a_alarm_lag_end: assert property (
    (alarm_match && st_r.icr[`RTCS_ICR_AEN] && st_r.alm_cnt == 11'h000 && st_r.xtal == 2'h2)
    |-> ##[304:304] (st_r.alm_flag && int_oe))
    else $error("alarm interrupt not asserted 7.6 us after match");

  a_per_asserts: assert property (
    per_set |=> int_oe ##0 st_r.per_flag)
    else $error("periodic event did not assert interrupt");

  a_per_held: assert property (
    (st_r.per_flag && !stat_rd) |=> st_r.per_flag)
    else $error("periodic interrupt released without status read");

  a_stat_rd_release: assert property (
    (stat_rd && !pf_set && !alm_set && !per_set) |=> !int_oe)
    else $error("status read did not release interrupt");

  a_int_wakes: assert property (
    (int_rise && st_r.pdn) |=> !st_r.pdn && st_r.evt[`RTCS_EV_WAKE])
    else $error("interrupt did not cancel power-down");

  a_pending_bit: assert property (
    $rose(int_oe) |-> ((status_byte(st_r) & (8'h01 << `RTCS_ST_INT)) != 8'h00) && $past(!int_any))
    else $error("pending status bit does not follow interrupt");

  a_mode_capture: assert property (
    (por_s && !st_r.por_d) |=> (st_r.supply == $past(vdd_s)))
    else $error("mode not taken from supply level at reset end");
endmodule

//--- src/rtcs_cfg.svh
// Constants of the serial RTC port: offsets, field positions, responses, timing.
// Assumes inclusion by the top module and the bench, by bare name.
`ifndef RTCS_CFG_SVH
`define RTCS_CFG_SVH
`define RTCS_CLK_MHZ      40
`define RTCS_LAG_32K_NS   30500
`define RTCS_LAG_2M_NS    15300
`define RTCS_LAG_4M_NS    7600
`define RTCS_NS2CYC(ns)   ((((ns) * `RTCS_CLK_MHZ) + 999) / 1000)
`define RTCS_LAG_32K_CYC  `RTCS_NS2CYC(`RTCS_LAG_32K_NS)
`define RTCS_LAG_2M_CYC   `RTCS_NS2CYC(`RTCS_LAG_2M_NS)
`define RTCS_LAG_4M_CYC   `RTCS_NS2CYC(`RTCS_LAG_4M_NS)
`define RTCS_XTAL_32K     2'h0
`define RTCS_XTAL_2M      2'h1
`define RTCS_PIN_CE       0
`define RTCS_PIN_SCK      1
`define RTCS_PIN_MOSI     2
`define RTCS_PIN_VDD      3
`define RTCS_PIN_POR      4
`define RTCS_ADR_WR       7
`define RTCS_ADR_REG      5
`define RTCS_REG_STAT     6'h30
`define RTCS_REG_ICR      6'h32
`define RTCS_ICR_PSE      5
`define RTCS_ICR_AEN      4
`define RTCS_ICR_PEN      3
`define RTCS_ST_INT       0
`define RTCS_ST_PF        1
`define RTCS_ST_ALM       2
`define RTCS_ST_PER       3
`define RTCS_ST_SUP       7
`define RTCS_AX_EVT       8'h00
`define RTCS_AX_MASK      8'h04
`define RTCS_AX_CTRL      8'h08
`define RTCS_AX_STATE     8'h0C
`define RTCS_RESP_OKAY    2'h0
`define RTCS_RESP_SLVERR  2'h2
`define RTCS_EV_BYTE      0
`define RTCS_EV_INT       1
`define RTCS_EV_WAKE      2
`define RTCS_CTRL_PDN     0
`define RTCS_CTRL_XTAL    1
`endif

//--- src/rtcs_pkg.sv
// Types of the serial RTC port: link state and the whole register state.
// Assumes the constants header is on the include path.
package rtcs_pkg;
  typedef enum logic [1:0] {
    RTCS_IDLE = 2'h0,
    RTCS_ADDR = 2'h1,
    RTCS_DATA = 2'h3
  } rtcs_spi_type;

  typedef struct packed {
    logic        aw_ok;
    logic        w_ok;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } rtcs_axi_type;

  typedef struct packed {
    logic [4:0]   sync1;
    logic [4:0]   sync2;
    logic         sck_d;
    logic         vdd_d;
    logic         por_d;
    rtcs_spi_type spi;
    logic [2:0]   bit_cnt;
    logic [7:0]   sh_in;
    logic [7:0]   sh_out;
    logic [7:0]   adr;
    logic         wr;
    logic         ld_pend;
    logic         miso;
    logic [7:0]   icr;
    logic         pf_flag;
    logic         alm_flag;
    logic         per_flag;
    logic [10:0]  alm_cnt;
    logic         supply;
    logic         pdn;
    logic         int_d;
    logic [2:0]   evt;
    logic [2:0]   mask;
    logic [1:0]   xtal;
    rtcs_axi_type ax;
  } rtcs_state_type;
endpackage

//--- src/rtcs_ram.sv
// Small user RAM of the serial RTC port, one write and one read port.
// Assumes a single clock; read data appear one edge after the address.
module rtcs_ram #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem_r [2**AW];

  // Contents survive resets, as battery-backed storage would
  always_ff @(posedge clock) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end
endmodule

//--- verif/rtcs_host.sv
// SPI host model in mode 0: one framed transfer per call of xfer.
// Assumes a 40 MHz clock; a serial bit takes 8 clocks, 200 ns.
module rtcs_host (
  input  wire logic clock,
  output logic      sck_pin,
  output logic      ce_pin,
  output logic      mosi_pin,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic line_r = 1'b0;
  initial begin
    sck_pin = 1'b0;
    ce_pin = 1'b0;
    mosi_pin = 1'b0;
  end
  // Shifts the top nbits of bits; rd keeps the last 16 line samples
  task automatic xfer(input logic [23:0] bits, input int nbits, output logic [15:0] rd);
    rd = 16'h0;
    @(posedge clock);
    ce_pin <= 1'b1;
    for (int i = 0; i < nbits; i++) begin
      mosi_pin <= bits[23-i];
      repeat (4) @(posedge clock);
      sck_pin <= 1'b1;
      repeat (4) @(posedge clock);
      // Sampled late in the bit, well clear of the output lag
      line_r = miso_oe ? miso_o : ~line_r;
      rd = {rd[14:0], line_r};
      sck_pin <= 1'b0;
    end
    repeat (4) @(posedge clock);
    ce_pin <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule

//--- verif/tb_top.sv
// Bench of the serial RTC port: AXI4-Lite master, SPI host, event pulses.
// Assumes the design, its package and the constants header compile first.
`include "rtcs_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        por_n = 1'b1;
  logic        vdd = 1'b1;
  logic        alm = 1'b0;
  logic        per = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d, seed;
  logic [1:0]  bresp, rresp, r;
  logic        awr, wr, bv, arr, rv, sck, ce, mosi, miso, moe, int_o, int_oe, pdn, sup, irq;
  wire logic   int_line = int_oe ? int_o : 1'b1;
  int          fail_count = 0;
  int          compares = 0;
  int          n;
  logic [15:0] rd, v;
  logic [4:0]  loc;
  rtcs_top dut_u (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .sck_pin(sck), .ce_pin(ce), .mosi_pin(mosi), .miso_o(miso), .miso_oe(moe), .int_o(int_o),
    .int_oe(int_oe), .por_n_pin(por_n), .vdd_pin(vdd), .alarm_match(alm), .periodic_tick(per),
    .pwr_down(pdn), .supply_mode(sup), .irq(irq));
  rtcs_host host_u (.clock(clock), .sck_pin(sck), .ce_pin(ce), .mosi_pin(mosi), .miso_o(miso),
    .miso_oe(moe));
  initial begin
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int lag_of(input int x);
    return (x == 0) ? `RTCS_LAG_32K_CYC : (x == 1) ? `RTCS_LAG_2M_CYC : `RTCS_LAG_4M_CYC;
  endfunction
  // Status byte with supply mode set
  function automatic logic [31:0] stat_of(input logic f, input logic a, input logic p);
    return {24'h0, 4'h8, p, a, f, f | a | p};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic expire(input string nm);
    fail_count++;
    $display("mismatch %s expected answer seen timeout", nm);
    final_report();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] val, output logic [1:0] resp);
    @(posedge clock);
    awa <= a;
    wd <= val;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge clock);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        resp = bresp;
        brd <= 1'b0;
        return;
      end
    end
    expire("axi write");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] val, output logic [1:0] resp);
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge clock);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        val = rdat;
        resp = rresp;
        rrd <= 1'b0;
        return;
      end
    end
    expire("axi read");
  endtask
  task automatic pulse(input logic is_alarm);
    @(posedge clock);
    if (is_alarm) alm <= 1'b1;
    else per <= 1'b1;
    @(posedge clock);
    alm <= 1'b0;
    per <= 1'b0;
  endtask
  initial begin
    seed = 32'd90434;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clock);
    chk("supply mode", 32'(sup), 1);
    chk("int idle", 32'(int_line), 1);
    por_n <= 1'b0;
    vdd <= 1'b0;
    repeat (10) @(posedge clock);
    por_n <= 1'b1;
    repeat (10) @(posedge clock);
    chk("battery mode", 32'(sup), 0);
    vdd <= 1'b1;
    repeat (10) @(posedge clock);
    chk("supply on rise", 32'(sup), 1);
    $display("test mode done");
    for (int t = 0; t < 3; t++) begin
      seed = lfsr(seed);
      loc = (t == 0) ? 5'h1F : seed[4:0];
      v = seed[23:8];
      host_u.xfer({3'h4, loc, v}, 24, rd);
      host_u.xfer({3'h0, loc, 16'h0}, 24, rd);
      chk("ram pair", 32'(rd), 32'(v));
      chk("miso released", 32'(moe), 0);
    end
    host_u.xfer({3'h4, loc, ~v}, 13, rd);
    host_u.xfer({3'h0, loc, 16'h0}, 16, rd);
    chk("aborted write", 32'(rd[7:0]), 32'(v[15:8]));
    $display("test serial done");
    host_u.xfer({8'hB2, 8'h38, 8'h00}, 16, rd);
    host_u.xfer({8'h32, 16'h0}, 16, rd);
    chk("icr readback", 32'(rd[7:0]), 32'h38);
    pulse(1'b0);
    repeat (4) @(posedge clock);
    chk("periodic int", 32'(int_line), 0);
    chk("irq masked", 32'(irq), 0);
    axi_wr(`RTCS_AX_MASK, 32'h2, r);
    chk("irq raised", 32'(irq), 1);
    axi_wr(`RTCS_AX_EVT, 32'h7, r);
    chk("irq cleared", 32'(irq), 0);
    host_u.xfer({8'h30, 16'h0}, 16, rd);
    chk("status periodic", 32'(rd[7:0]), stat_of(0, 0, 1));
    chk("periodic release", 32'(int_line), 1);
    vdd <= 1'b0;
    repeat (8) @(posedge clock);
    chk("power fail int", 32'(int_line), 0);
    host_u.xfer({8'h30, 16'h0}, 16, rd);
    chk("status fail", 32'(rd[6:0]), stat_of(1, 0, 0) & 32'h7F);
    chk("fail release", 32'(int_line), 1);
    vdd <= 1'b1;
    $display("test events done");
    for (int x = 0; x < 4; x++) begin
      axi_wr(`RTCS_AX_CTRL, 32'(x << 1), r);
      pulse(1'b1);
      n = 0;
      while (int_oe !== 1'b1 && n < 1300) begin
        @(posedge clock);
        n++;
      end
      if (n >= 1300) expire("alarm wait");
      chk("alarm lag", 32'(n >= lag_of(x) && n <= lag_of(x) + 3), 1);
      host_u.xfer({8'h30, 16'h0}, 16, rd);
      chk("status alarm", 32'(rd[7:0]), stat_of(0, 1, 0));
      chk("alarm release", 32'(int_line), 1);
    end
    $display("test alarm done");
    axi_wr(`RTCS_AX_CTRL, 32'h1, r);
    repeat (2) @(posedge clock);
    chk("power down", 32'(pdn), 1);
    pulse(1'b0);
    repeat (3) @(posedge clock);
    chk("power down cancel", 32'(pdn), 0);
    axi_rd(`RTCS_AX_EVT, d, r);
    chk("wake event", 32'(d[2]), 1);
    host_u.xfer({8'h30, 16'h0}, 16, rd);
    axi_wr(8'h10, 32'h0, r);
    chk("write unmapped", 32'(r), 32'(`RTCS_RESP_SLVERR));
    axi_rd(8'h10, d, r);
    chk("read unmapped", 32'(r), 32'(`RTCS_RESP_SLVERR));
    host_u.xfer({8'hB2, 8'h00, 8'h00}, 16, rd);
    pulse(1'b0);
    repeat (4) @(posedge clock);
    chk("disabled event", 32'(int_line), 1);
    axi_wr(`RTCS_AX_STATE, 32'hFFFFFFFF, r);
    chk("write state", 32'(r), 32'(`RTCS_RESP_OKAY));
    axi_rd(`RTCS_AX_STATE, d, r);
    chk("state word", d, 32'h10000 | (stat_of(0, 0, 0) << 8));
    $display("test control done");
    final_report();
  end
endmodule
